//--- shared/wdt_pkg.sv
// Package: offsets, fields, keys and counts of the watchdog/interval timer
package wdt_pkg;
    localparam logic [15:0] ADDR_CTRL_STATUS = 16'hffa8;
    localparam logic [15:0] ADDR_COUNT       = 16'hffa9;
    localparam logic [7:0]  KEY_COUNT        = 8'h5a;
    localparam logic [7:0]  KEY_CTRL         = 8'ha5;
    localparam int          BIT_OVF          = 7;
    localparam int          BIT_MODE         = 6;
    localparam int          BIT_ENABLE       = 5;
    localparam int          BIT_PSRC         = 4;
    localparam int          BIT_RSTSEL       = 3;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  COUNT_RESET      = 8'h00;
    localparam logic [7:0]  COUNT_MAX        = 8'hff;
    localparam int          WDT_RESET_CYCLES = 518;
    localparam logic [9:0]  WDT_RESET_LEN    = 10'(WDT_RESET_CYCLES);
    localparam int          MAIN_DIV_W       = 17;
    localparam int          SUB_DIV_W        = 8;
    typedef enum logic [0:0] {
        WDT_IDLE    = 1'b0,
        WDT_RESETNG = 1'b1
    } wdt_rst_state_t;
endpackage : wdt_pkg

//--- design/wdt_prescaler.sv
// Free-running main and sub-clock prescalers with tap select
module wdt_prescaler (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       subClkTick,
    input  wire logic       prescalerSourceSelect,
    input  wire logic [2:0] clockSelect,
    output logic            countTick
);
    logic [wdt_pkg::MAIN_DIV_W-1:0] mainCnt_q;
    logic [wdt_pkg::SUB_DIV_W-1:0]  subCnt_q;
    logic [wdt_pkg::MAIN_DIV_W-1:0] mainPrev_q;
    logic [wdt_pkg::SUB_DIV_W-1:0]  subPrev_q;
    logic                           tick_q;

    // Main taps: /2 /64 /128 /512 /2048 /8192 /32768 /131072
    function automatic int mainTap(input logic [2:0] sel);
        unique case (sel)
            3'h0: mainTap = 0;
            3'h1: mainTap = 5;
            3'h2: mainTap = 6;
            3'h3: mainTap = 8;
            3'h4: mainTap = 10;
            3'h5: mainTap = 12;
            3'h6: mainTap = 14;
            3'h7: mainTap = 16;
        endcase
    endfunction : mainTap

    wire mainFall = mainPrev_q[mainTap(clockSelect)] & ~mainCnt_q[mainTap(clockSelect)];
    wire subFall  = subPrev_q[clockSelect] & ~subCnt_q[clockSelect];
    wire tick_d   = prescalerSourceSelect ? subFall : mainFall;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mainCnt_q  <= '0;
            subCnt_q   <= '0;
            mainPrev_q <= '0;
            subPrev_q  <= '0;
            tick_q     <= 1'b0;
        end else begin
            mainCnt_q  <= mainCnt_q + 1'b1;
            mainPrev_q <= mainCnt_q;
            if (subClkTick) begin
                subCnt_q <= subCnt_q + 1'b1;
            end
            subPrev_q  <= subCnt_q;
            tick_q     <= tick_d;
        end
    end

    assign countTick = tick_q;
endmodule : wdt_prescaler

//--- design/wdt_timer.sv
// Watchdog / interval timer with keyed word writes and byte reads
module wdt_timer (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        subClkTick,
    input  wire logic [15:0] busAddr,
    input  wire logic        busWrite,
    input  wire logic        busWordWrite,
    input  wire logic        busRead,
    input  wire logic [15:0] busWrData,
    input  wire logic        externalResetPin_n,
    input  wire logic        externalNmiPin,
    output logic [7:0]       busRdData,
    output logic             internalReset,
    output logic             resetSourceBit,
    output logic             nmiRequest,
    output logic             intervalInterrupt
);
    logic [7:0]                     ctrl_q;
    logic [7:0]                     count_q;
    logic                           ovfSeen_q;
    wdt_pkg::wdt_rst_state_t        rstState_q;
    logic [9:0]                     rstCnt_q;
    logic [7:0]                     rdData_q;
    logic                           intReset_q;
    logic                           srcBit_q;
    logic                           nmi_q;
    logic                           ivi_q;
    logic                           countTick;

    wdt_prescaler uPrescaler (
        .clk                   (clk),
        .resetn                (resetn),
        .subClkTick            (subClkTick),
        .prescalerSourceSelect (ctrl_q[wdt_pkg::BIT_PSRC]),
        .clockSelect           (ctrl_q[2:0]),
        .countTick             (countTick)
    );

    wire enable      = ctrl_q[wdt_pkg::BIT_ENABLE];
    wire watchdog    = ctrl_q[wdt_pkg::BIT_MODE] & enable;
    wire rstSelect   = ctrl_q[wdt_pkg::BIT_RSTSEL];
    // Byte writes never match: only the word strobe qualifies the key check
    wire wordWr      = busWrite & busWordWrite & (busAddr == wdt_pkg::ADDR_CTRL_STATUS);
    wire wrCount     = wordWr & (busWrData[15:8] == wdt_pkg::KEY_COUNT);
    wire wrCtrl      = wordWr & (busWrData[15:8] == wdt_pkg::KEY_CTRL);
    wire incr        = enable & countTick & ~wrCount;
    wire overflow    = incr & (count_q == wdt_pkg::COUNT_MAX);
    wire wdOverflow  = overflow & watchdog;
    wire wdReset     = wdOverflow & rstSelect;
    wire wdNmi       = wdOverflow & ~rstSelect;
    wire rdCtrl      = busRead & (busAddr == wdt_pkg::ADDR_CTRL_STATUS);
    wire rdCount     = busRead & (busAddr == wdt_pkg::ADDR_COUNT);
    wire newEnable   = wrCtrl ? busWrData[wdt_pkg::BIT_ENABLE] : enable;
    wire ovfClrWr    = wrCtrl & ~busWrData[wdt_pkg::BIT_OVF] & ovfSeen_q;
    // Flag is cleared by writing zero after reading it as one, or by clearing enable; a set in the same cycle wins over the clear
    wire ovfNext     = overflow | (ctrl_q[wdt_pkg::BIT_OVF] & ~ovfClrWr & newEnable);
    wire rstActive   = (rstState_q == wdt_pkg::WDT_RESETNG);
    wire rstDone     = rstActive & (rstCnt_q == wdt_pkg::WDT_RESET_LEN - 10'h001);
    wire [7:0] ctrlBase = wrCtrl ? {1'b0, busWrData[6:0]} : {1'b0, ctrl_q[6:0]};
    wire [7:0] ctrl_d   = {ovfNext, ctrlBase[6:0]};
    wire [7:0] count_d  = ~newEnable ? wdt_pkg::COUNT_RESET :
                          wrCount ? busWrData[7:0] :
                          incr ? count_q + 8'h01 : count_q;
    wire [7:0] rd_d     = rdCtrl ? ctrl_q : rdCount ? count_q : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q    <= wdt_pkg::CTRL_RESET;
            count_q   <= wdt_pkg::COUNT_RESET;
            ovfSeen_q <= 1'b0;
        end else if (rstActive) begin
            // Internal reset returns the timer to its reset state, flag included
            ctrl_q    <= wdt_pkg::CTRL_RESET;
            count_q   <= wdt_pkg::COUNT_RESET;
            ovfSeen_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            count_q   <= count_d;
            if (rdCtrl) begin
                ovfSeen_q <= ctrl_q[wdt_pkg::BIT_OVF];
            end else if (ovfClrWr | ~ovfNext) begin
                // Flag cleared any way must be read as one again first
                ovfSeen_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstState_q <= wdt_pkg::WDT_IDLE;
            rstCnt_q   <= 10'h000;
        end else begin
            unique case (rstState_q)
                wdt_pkg::WDT_IDLE: begin
                    if (wdReset) begin
                        rstState_q <= wdt_pkg::WDT_RESETNG;
                    end
                    rstCnt_q <= 10'h000;
                end
                wdt_pkg::WDT_RESETNG: begin
                    rstCnt_q <= rstCnt_q + 10'h001;
                    if (rstDone) begin
                        rstState_q <= wdt_pkg::WDT_IDLE;
                    end
                end
            endcase
        end
    end

    // Reset-source bit: set by pin reset, which has priority; cleared by watchdog-only reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            srcBit_q <= 1'b1;
        end else if (!externalResetPin_n) begin
            srcBit_q <= 1'b1;
        end else if (wdReset) begin
            srcBit_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_q   <= 8'h00;
            intReset_q <= 1'b0;
            nmi_q      <= 1'b0;
            ivi_q      <= 1'b0;
        end else begin
            rdData_q   <= rd_d;
            intReset_q <= wdReset | (rstActive & ~rstDone);
            // Two NMI sources share one vector and cannot be told apart
            nmi_q      <= wdNmi | externalNmiPin;
            ivi_q      <= ovfNext & ~ctrl_d[wdt_pkg::BIT_MODE] & ~rstActive;
        end
    end

    assign busRdData         = rdData_q;
    assign internalReset     = intReset_q;
    assign resetSourceBit    = srcBit_q;
    assign nmiRequest        = nmi_q;
    assign intervalInterrupt = ivi_q;
endmodule : wdt_timer

//--- verif/wdt_timer_sva.sv
// Port assertions for the watchdog timer
module wdt_timer_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        subClkTick,
    input wire logic [15:0] busAddr,
    input wire logic        busWrite,
    input wire logic        busWordWrite,
    input wire logic        busRead,
    input wire logic [15:0] busWrData,
    input wire logic        externalResetPin_n,
    input wire logic        externalNmiPin,
    input wire logic [7:0]  busRdData,
    input wire logic        internalReset,
    input wire logic        resetSourceBit,
    input wire logic        nmiRequest,
    input wire logic        intervalInterrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] hiCnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Too long for a repetition, so count it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hiCnt_q <= 10'h000;
        end else begin
            hiCnt_q <= internalReset ? hiCnt_q + 10'h001 : 10'h000;
        end
    end
    AST_RST_LEN: assert property ($fell(internalReset) |-> hiCnt_q == wdt_pkg::WDT_RESET_LEN)
        else $error("reset length");
    AST_RD_IDLE: assert property (!busRead |=> busRdData == 8'h00)
        else $error("stray read data");
    AST_RD_HELD: assert property (internalReset && $past(internalReset) && busRead |=> busRdData == 8'h00)
        else $error("registers not held");
    AST_NMI_PIN: assert property (externalNmiPin |=> nmiRequest)
        else $error("pin nmi lost");
    AST_INT_FLAG: assert property (busRead && busAddr == wdt_pkg::ADDR_CTRL_STATUS |=>
        intervalInterrupt == (busRdData[7] && !busRdData[6])) else $error("interrupt vs flag");
    AST_SRC_WDT: assert property ($fell(internalReset) && externalResetPin_n |-> !resetSourceBit)
        else $error("source not timer");
    AST_SRC_PIN: assert property (!externalResetPin_n |=> resetSourceBit)
        else $error("pin not winning");
    AST_INT_OFF: assert property (internalReset |-> !intervalInterrupt)
        else $error("interrupt in reset");
endmodule : wdt_timer_sva
bind wdt_timer wdt_timer_sva u_wdt_timer_sva (.clk(clk), .resetn(resetn), .subClkTick(subClkTick),
    .busAddr(busAddr), .busWrite(busWrite), .busWordWrite(busWordWrite), .busRead(busRead), .busWrData(busWrData),
    .externalResetPin_n(externalResetPin_n), .externalNmiPin(externalNmiPin), .busRdData(busRdData),
    .internalReset(internalReset), .resetSourceBit(resetSourceBit), .nmiRequest(nmiRequest),
    .intervalInterrupt(intervalInterrupt));

//--- verif/wdt_subclk_model.sv
// Sub-clock tick source for the slow prescaler
module wdt_subclk_model #(
    parameter int PERIOD = 4
) (
    input  wire logic clk,
    input  wire logic resetn,
    output logic      subClkTick
);
    timeunit 1ns;
    timeprecision 100ps;
    int n = 0;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) n <= 0;
        else n <= (n == PERIOD - 1) ? 0 : n + 1;
    end
    assign subClkTick = (n == PERIOD - 1);
endmodule : wdt_subclk_model

//--- verif/tb.sv
// Testbench for the watchdog timer
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        subClkTick;
    logic [15:0] busAddr = 16'h0000;
    logic        busWrite = 1'b0;
    logic        busWordWrite = 1'b0;
    logic        busRead = 1'b0;
    logic [15:0] busWrData = 16'h0000;
    logic        externalResetPin_n = 1'b1;
    logic        externalNmiPin = 1'b0;
    logic [7:0]  busRdData;
    logic        internalReset;
    logic        resetSourceBit;
    logic        nmiRequest;
    logic        intervalInterrupt;
    logic [7:0]  rd;
    logic [7:0]  rdPrev;
    int          error_cnt = 0;
    int          checks_done = 0;
    always #5 clk = ~clk;
    wdt_subclk_model u_wdt_subclk_model (.clk(clk), .resetn(resetn), .subClkTick(subClkTick));
    wdt_timer u_wdt_timer (.clk(clk), .resetn(resetn), .subClkTick(subClkTick), .busAddr(busAddr),
        .busWrite(busWrite), .busWordWrite(busWordWrite), .busRead(busRead), .busWrData(busWrData),
        .externalResetPin_n(externalResetPin_n), .externalNmiPin(externalNmiPin), .busRdData(busRdData),
        .internalReset(internalReset), .resetSourceBit(resetSourceBit), .nmiRequest(nmiRequest),
        .intervalInterrupt(intervalInterrupt));
    task automatic wr(input logic [15:0] d, input logic w);
        @(posedge clk);
        busWrite <= 1'b1;
        busWordWrite <= w;
        busAddr <= wdt_pkg::ADDR_CTRL_STATUS;
        busWrData <= d;
        @(posedge clk);
        busWrite <= 1'b0;
    endtask : wr
    task automatic rdReg(input logic c);
        @(posedge clk);
        busRead <= 1'b1;
        busAddr <= c ? wdt_pkg::ADDR_COUNT : wdt_pkg::ADDR_CTRL_STATUS;
        @(posedge clk);
        busRead <= 1'b0;
        #1 rd = busRdData;
    endtask : rdReg
    task automatic rdChk(input logic c, input logic [7:0] e);
        rdReg(c);
        `CHK(rd, e)
    endtask : rdChk
    function automatic logic sig(input int s);
        case (s)
            0: return intervalInterrupt;
            1: return nmiRequest;
            2: return internalReset;
            default: return !internalReset;
        endcase
    endfunction : sig
    // Bounded so a dead timer cannot hang the run
    task automatic waitSig(input int s);
        int n;
        n = 0;
        // Sampled off the edge so a one-cycle pulse is still seen
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (sig(s) !== 1'b1 && n < 2000);
        `CHK(sig(s), 1'b1)
    endtask : waitSig
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    initial begin
        #100us;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rdChk(1'b0, 8'h00);
        `CHK(resetSourceBit, 1'b1)
        rdChk(1'b1, 8'h00);
        wr(16'ha520, 1'b0);
        rdChk(1'b0, 8'h00);
        wr(16'h3320, 1'b1);
        rdChk(1'b0, 8'h00);
        wr(16'ha520, 1'b1);
        rdChk(1'b0, 8'h20);
        wr(16'h5a80, 1'b1);
        rdReg(1'b1);
        rdPrev = rd;
        `CHK(rd inside {8'h80, 8'h81}, 1'b1)
        // Odd offset puts the second write on the other tick phase
        @(posedge clk);
        wr(16'h5a80, 1'b1);
        rdReg(1'b1);
        `CHK({rdPrev, rd} inside {16'h8081, 16'h8180}, 1'b1)
        wr(16'h5afe, 1'b1);
        waitSig(0);
        rdChk(1'b0, 8'ha0);
        wr(16'ha520, 1'b1);
        rdChk(1'b0, 8'h20);
        `CHK(intervalInterrupt, 1'b0)
        wr(16'h5afe, 1'b1);
        waitSig(0);
        wr(16'ha520, 1'b1);
        rdChk(1'b0, 8'ha0);
        wr(16'ha520, 1'b1);
        rdChk(1'b0, 8'h20);
        wr(16'ha500, 1'b1);
        rdChk(1'b1, 8'h00);
        wr(16'ha560, 1'b1);
        wr(16'h5afe, 1'b1);
        waitSig(1);
        `CHK(internalReset, 1'b0)
        wr(16'ha540, 1'b1);
        @(posedge clk) externalNmiPin <= 1'b1;
        @(posedge clk) externalNmiPin <= 1'b0;
        #1 `CHK(nmiRequest, 1'b1)
        wr(16'ha568, 1'b1);
        repeat (3) begin
            repeat (300) @(posedge clk);
            wr(16'h5a00, 1'b1);
        end
        #1 `CHK(internalReset, 1'b0)
        wr(16'h5afe, 1'b1);
        waitSig(2);
        // Writes during the internal reset must not land
        wr(16'ha520, 1'b1);
        rdChk(1'b0, 8'h00);
        waitSig(3);
        rdChk(1'b0, 8'h00);
        `CHK(resetSourceBit, 1'b0)
        @(posedge clk) externalResetPin_n <= 1'b0;
        @(posedge clk) externalResetPin_n <= 1'b1;
        #1 `CHK(resetSourceBit, 1'b1)
        wr(16'ha530, 1'b1);
        repeat (100) @(posedge clk);
        rdReg(1'b1);
        `CHK(rd inside {8'h0c, 8'h0d}, 1'b1)
        wr(16'ha510, 1'b1);
        wr(16'ha537, 1'b1);
        repeat (2100) @(posedge clk);
        rdReg(1'b1);
        `CHK(rd inside {8'h02, 8'h03}, 1'b1)
        wr(16'ha510, 1'b1);
        wr(16'ha521, 1'b1);
        repeat (256) @(posedge clk);
        rdReg(1'b1);
        `CHK(rd inside {8'h04, 8'h05}, 1'b1)
        complete_run();
    end
endmodule : tb
